// [temp_readout_pkg.sv]
// constants shared by the temperature readout register bank
// assumes one clock domain and a command-coded byte read port
`default_nettype none
package temp_readout_pkg;
  // ****************
  // channel shape
  // ****************
  localparam int NUM_CHAN = 5;
  localparam int INT_W    = 8;
  localparam int FRAC_W   = 5;
  localparam int TEMP_W   = INT_W + FRAC_W;
  localparam int PAD_W    = 3;
  // ****************
  // command codes
  // ****************
  localparam logic [7:0] CMD_LOCAL_HIGH   = 8'h10;
  localparam logic [7:0] CMD_REMOTE1_HIGH = 8'h11;
  localparam logic [7:0] CMD_REMOTE2_HIGH = 8'h12;
  localparam logic [7:0] CMD_REMOTE3_HIGH = 8'h13;
  localparam logic [7:0] CMD_REMOTE4_HIGH = 8'h14;
  localparam logic [7:0] CMD_LOCAL_LOW    = 8'h20;
  localparam logic [7:0] CMD_REMOTE1_LOW  = 8'h21;
  localparam logic [7:0] CMD_REMOTE2_LOW  = 8'h22;
  localparam logic [7:0] CMD_REMOTE3_LOW  = 8'h23;
  localparam logic [7:0] CMD_REMOTE4_LOW  = 8'h24;
  // ****************
  // field masks and reset values
  // ****************
  localparam logic [FRAC_W-1:0] FRAC_MASK_COARSE = 5'h1c;
  localparam logic [FRAC_W-1:0] FRAC_MASK_FINE   = 5'h1f;
  localparam logic [TEMP_W-1:0] TEMP_RESET       = 13'h0000;
  localparam logic [7:0]        UNMAPPED_DATA    = 8'h00;
  typedef logic [TEMP_W-1:0] temp_t;
endpackage : temp_readout_pkg
`default_nettype wire

// [temp_chan_if.sv]
// signals passed between the readout top, its decoder and its channels
// assumes all parties run on the same clock
`default_nettype none
interface temp_chan_if;
  import temp_readout_pkg::*;
  logic                    ce;
  logic                    rdReq;
  logic [7:0]              rdCmd;
  logic [NUM_CHAN-1:0]     upd;
  temp_t                   temp     [NUM_CHAN];
  logic [FRAC_W-1:0]       fracMask [NUM_CHAN];
  logic [NUM_CHAN-1:0]     rdHi;
  logic [NUM_CHAN-1:0]     rdLo;
  logic [7:0]              hiByte   [NUM_CHAN];
  logic [7:0]              loByte   [NUM_CHAN];
  logic                    locked   [NUM_CHAN];
  modport top  (output ce, rdReq, rdCmd, upd, temp, fracMask,
                input rdHi, rdLo, hiByte, loByte, locked);
  modport dec  (input rdReq, rdCmd, output rdHi, rdLo);
  modport chan (input ce, upd, temp, fracMask, rdHi, rdLo,
                output hiByte, loByte, locked);
endinterface : temp_chan_if
`default_nettype wire

// [temp_cmd_decode.sv]
// turns a read request and command code into per-channel high/low strobes
// assumes the request is qualified by the clock enable upstream
`default_nettype none
module temp_cmd_decode
  import temp_readout_pkg::*;
(
  temp_chan_if.dec bus
);
  localparam logic [7:0] HIGH_CMD [NUM_CHAN] = '{CMD_LOCAL_HIGH, CMD_REMOTE1_HIGH,
    CMD_REMOTE2_HIGH, CMD_REMOTE3_HIGH, CMD_REMOTE4_HIGH};
  localparam logic [7:0] LOW_CMD [NUM_CHAN] = '{CMD_LOCAL_LOW, CMD_REMOTE1_LOW,
    CMD_REMOTE2_LOW, CMD_REMOTE3_LOW, CMD_REMOTE4_LOW};
  // ****************
  // one-hot strobes
  // ****************
  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_dec
    assign bus.rdHi[i] = bus.rdReq && (bus.rdCmd == HIGH_CMD[i]);
    assign bus.rdLo[i] = bus.rdReq && (bus.rdCmd == LOW_CMD[i]);
  end
endmodule // temp_cmd_decode
`default_nettype wire

// [temp_chan_lock.sv]
// one channel: live conversion result plus frozen low byte
// assumes at most one of rdHi/rdLo per cycle for this channel
`default_nettype none
module temp_chan_lock
  import temp_readout_pkg::*;
#(
  parameter int CH = 0
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  temp_chan_if.chan bus
);
  temp_t             liveQ;
  logic [FRAC_W-1:0] frozQ;
  logic              lockQ;
  logic [FRAC_W-1:0] fracSel;
  // ****************
  // state
  // ****************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      liveQ <= TEMP_RESET;
      frozQ <= '0;
      lockQ <= 1'b0;
    end else if (bus.ce) begin
      if (bus.upd[CH]) begin
        liveQ <= bus.temp[CH];
      end
      if (bus.rdHi[CH]) begin
        frozQ <= liveQ[FRAC_W-1:0];
        lockQ <= 1'b1;
      end else if (bus.rdLo[CH]) begin
        lockQ <= 1'b0;
      end
    end
  end
  // ****************
  // byte views
  // ****************
  assign fracSel         = lockQ ? frozQ : liveQ[FRAC_W-1:0];
  assign bus.hiByte[CH]  = liveQ[TEMP_W-1:FRAC_W];
  assign bus.loByte[CH]  = {fracSel & bus.fracMask[CH], {PAD_W{1'b0}}};
  assign bus.locked[CH]  = lockQ;
endmodule // temp_chan_lock
`default_nettype wire

// [temp_value_readout_regs.sv]
// read-only temperature result registers with high/low byte coherency lock
// assumes conversion results and read requests come from logic on ref_clk
`default_nettype none
module temp_value_readout_regs
  import temp_readout_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                rdEn,
  input  wire logic [7:0]          rdCmd,
  output logic                     rdValid,
  output logic [7:0]               rdData,
  input  wire logic [NUM_CHAN-1:0] convValid,
  input  wire temp_readout_pkg::temp_t convLocal,
  input  wire temp_readout_pkg::temp_t convRemote1,
  input  wire temp_readout_pkg::temp_t convRemote2,
  input  wire temp_readout_pkg::temp_t convRemote3,
  input  wire temp_readout_pkg::temp_t convRemote4,
  input  wire logic [1:0]          filterOn,
  input  wire logic [7:0]          localLimit,
  output logic                     localOver,
  output logic                     localErrEvent,
  output logic [NUM_CHAN-1:0]      lowLocked
);
  import temp_readout_pkg::*;

  temp_chan_if bus ();

  logic [7:0]          rdDataQ;
  logic [7:0]          rdDataD;
  logic                rdValidQ;
  logic                localOverQ;
  logic                localOverD;
  logic                localEvtQ;
  logic                hiHit;
  logic                loHit;
  logic [7:0]          hiSel;
  logic [7:0]          loSel;
  logic [NUM_CHAN-1:0] lockVec;

  // ****************
  // inputs onto the channel carrier
  // ****************
  assign bus.ce    = ce;
  assign bus.rdReq = rdEn && ce;
  assign bus.rdCmd = rdCmd;
  assign bus.upd   = convValid;
  assign bus.temp[0] = convLocal;
  assign bus.temp[1] = convRemote1;
  assign bus.temp[2] = convRemote2;
  assign bus.temp[3] = convRemote3;
  assign bus.temp[4] = convRemote4;

  // local and unfiltered remotes keep eighth-degree resolution
  assign bus.fracMask[0] = FRAC_MASK_COARSE;
  assign bus.fracMask[1] = filterOn[0] ? FRAC_MASK_FINE : FRAC_MASK_COARSE;
  assign bus.fracMask[2] = filterOn[1] ? FRAC_MASK_FINE : FRAC_MASK_COARSE;
  assign bus.fracMask[3] = FRAC_MASK_COARSE;
  assign bus.fracMask[4] = FRAC_MASK_COARSE;

  // ****************
  // decode and channels
  // ****************
  temp_cmd_decode u_dec (
    .bus (bus)
  );

  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    temp_chan_lock #(
      .CH (i)
    ) u_chan (
      .ref_clk (ref_clk),
      .rst     (rst),
      .bus     (bus)
    );
    assign lockVec[i] = bus.locked[i];
  end

  // ****************
  // read data selection
  // ****************
  always_comb begin
    hiSel = UNMAPPED_DATA;
    loSel = UNMAPPED_DATA;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (bus.rdHi[i]) begin
        hiSel = bus.hiByte[i];
      end
      if (bus.rdLo[i]) begin
        loSel = bus.loByte[i];
      end
    end
  end

  assign hiHit   = |bus.rdHi;
  assign loHit   = |bus.rdLo;
  assign rdDataD = hiHit ? hiSel : (loHit ? loSel : UNMAPPED_DATA);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdDataQ  <= UNMAPPED_DATA;
      rdValidQ <= 1'b0;
    end else if (ce) begin
      rdValidQ <= rdEn;
      if (rdEn) begin
        rdDataQ <= rdDataD;
      end
    end
  end

  // ****************
  // local temperature error
  // ****************
  assign localOverD = $signed(bus.hiByte[0]) > $signed(localLimit);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      localOverQ <= 1'b0;
      localEvtQ  <= 1'b0;
    end else if (ce) begin
      localOverQ <= localOverD;
      localEvtQ  <= localOverD && !localOverQ;
    end
  end

  // ****************
  // outputs
  // ****************
  assign rdValid       = rdValidQ;
  assign rdData        = rdDataQ;
  assign localOver     = localOverQ;
  assign localErrEvent = localEvtQ;
  assign lowLocked     = lockVec;
endmodule // temp_value_readout_regs
`default_nettype wire

// [rd_properties.sv]
// port checker for the temperature readout bank
// assumes one clock, rst high resets
`default_nettype none
module rd_properties
  import temp_readout_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       rdEn,
  input wire logic [7:0] rdCmd,
  input wire logic       rdValid,
  input wire logic [7:0] rdData,
  input wire logic [1:0] filterOn,
  input wire logic       localOver,
  input wire logic       localErrEvent,
  input wire logic [4:0] lowLocked
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic isHi = ce && rdEn && rdCmd >= CMD_LOCAL_HIGH && rdCmd <= CMD_REMOTE4_HIGH;
  wire logic isLo = ce && rdEn && rdCmd >= CMD_LOCAL_LOW && rdCmd <= CMD_REMOTE4_LOW;
  a_lock_on_high: assert property (isHi |=> lowLocked[$past(rdCmd[2:0])])
    else $error("high read left low byte unlocked");
  a_unlock_on_low: assert property (isLo |=> !lowLocked[$past(rdCmd[2:0])])
    else $error("low read left lock set");
  a_lock_holds: assert property (lowLocked[0] && !(ce && rdEn && rdCmd == CMD_LOCAL_LOW) |=> lowLocked[0])
    else $error("local lock dropped without low read");
  a_read_answers: assert property (ce && rdEn |=> rdValid)
    else $error("read not answered next cycle");
  a_local_pad_zero: assert property (rdValid && $past(isLo && rdCmd == CMD_LOCAL_LOW) |-> rdData[4:0] == 5'h00)
    else $error("local low pad bits set");
  a_remote_pad_zero: assert property (rdValid && $past(isLo && rdCmd != CMD_LOCAL_LOW) |-> rdData[2:0] == 3'h0)
    else $error("remote low pad bits set");
  a_coarse_low_zero: assert property (rdValid && $past(isLo && (rdCmd >= CMD_REMOTE3_LOW
    || rdCmd == CMD_REMOTE1_LOW && !filterOn[0]
    || rdCmd == CMD_REMOTE2_LOW && !filterOn[1])) |-> rdData[4:3] == 2'h0)
    else $error("coarse low byte has fine bits");
  a_event_needs_over: assert property (localErrEvent |-> localOver)
    else $error("error event without over level");
endmodule // rd_properties
bind temp_value_readout_regs rd_properties rd_properties_inst (.ref_clk, .rst, .ce, .rdEn, .rdCmd, .rdValid,
  .rdData, .filterOn, .localOver, .localErrEvent, .lowLocked);
`default_nettype wire

// [host_reader.sv]
// host stand-in issuing one byte read at a time by command code
// assumes the bank answers within a few cycles
`default_nettype none
module host_reader (
  input  wire logic       ref_clk,
  output logic            rdEn,
  output logic [7:0]      rdCmd,
  input  wire logic       rdValid,
  input  wire logic [7:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rdEn = 1'b0;
  initial rdCmd = 8'h00;
  // caller reads high before low for paired bytes
  task automatic read(input logic [7:0] cmd, output logic [7:0] data, output bit ok);
    ok = 0;
    @(negedge ref_clk);
    rdEn = 1'b1;
    rdCmd = cmd;
    @(negedge ref_clk);
    rdEn = 1'b0;
    rdCmd = ~cmd;
    for (int i = 0; i < 4 && !ok; i++) begin
      ok = rdValid === 1'b1;
      data = rdData;
      if (!ok) @(negedge ref_clk);
    end
  endtask
endmodule // host_reader
`default_nettype wire

// [testbench.sv]
// self-checking bench for the temperature readout bank
// assumes host_reader and the checker are compiled first
`default_nettype none
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin errCount++; $display("mismatch %s %h %h", n, e, g); end end
module testbench;
  import temp_readout_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0, rst = 1, ce = 1, rdEn, rdValid, localOver, localErrEvent, ok;
  logic [7:0]  rdCmd, rdData, got, localLimit = 0;
  logic [4:0]  convValid = 0, lowLocked;
  logic [1:0]  filterOn = 0;
  temp_t       conv [5] = '{default: 0};
  temp_t       cur [5], held;
  int          errCount = 0, checkCount = 0;
  initial forever #5 ref_clk = ~ref_clk;
  temp_value_readout_regs temp_value_readout_regs_inst (.ref_clk, .rst, .ce, .rdEn, .rdCmd, .rdValid, .rdData,
    .convValid, .convLocal(conv[0]), .convRemote1(conv[1]), .convRemote2(conv[2]), .convRemote3(conv[3]),
    .convRemote4(conv[4]), .filterOn, .localLimit, .localOver, .localErrEvent, .lowLocked);
  host_reader host_reader_inst (.ref_clk, .rdEn, .rdCmd, .rdValid, .rdData);
  function automatic logic [7:0] lo(int ch, temp_t v);
    logic fine;
    fine = (ch == 1 && filterOn[0]) || (ch == 2 && filterOn[1]);
    return {v[4:2], fine ? v[1:0] : 2'b00, 3'b000};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] e);
    host_reader_inst.read(cmd, got, ok);
    if (!ok) begin
      errCount++;
      conclude();
    end else begin
      `CHK("rdData", e, got)
    end
  endtask
  task automatic cv(input int ch, input temp_t v);
    @(negedge ref_clk);
    conv[ch] = v;
    cur[ch] = v;
    convValid = 5'h01 << ch;
    @(negedge ref_clk);
    convValid = 0;
  endtask
  initial begin
    void'($urandom(20));
    repeat (4) @(negedge ref_clk);
    rst = 0;
    for (int it = 0; it < 20; it++) begin
      filterOn = 2'($urandom);
      localLimit = 8'($urandom);
      for (int ch = 0; ch < 5; ch++) begin
        // first passes hit the signed extremes
        cv(ch, it == 0 ? 13'h1000 : it == 1 ? 13'h0fff : 13'($urandom));
        rd(8'h10 + ch[7:0], cur[ch][12:5]);
        cv(ch, 13'($urandom));
        rd(8'h10 + ch[7:0], cur[ch][12:5]);
        held = cur[ch];
        cv(ch, 13'($urandom));
        rd(8'h20 + ch[7:0], lo(ch, held));
        rd(8'h20 + ch[7:0], lo(ch, cur[ch]));
      end
      repeat (2) @(negedge ref_clk);
      `CHK("localOver", $signed(cur[0][12:5]) > $signed(localLimit), localOver)
      rd(8'h15, UNMAPPED_DATA);
      $display("test %0d done", it);
    end
    // clock enable low must drop a conversion strobe
    @(negedge ref_clk);
    ce = 1'b0;
    conv[0] = 13'($urandom);
    convValid = 5'h01;
    @(negedge ref_clk);
    convValid = 0;
    ce = 1'b1;
    rd(CMD_LOCAL_HIGH, cur[0][12:5]);
    // error event pulses once when the local reading passes the limit
    localLimit = 8'h7f;
    cv(0, 13'h0fe0);
    @(negedge ref_clk);
    `CHK("localErrEvent", 1'b0, localErrEvent)
    localLimit = 8'h00;
    @(negedge ref_clk);
    `CHK("localErrEvent", 1'b1, localErrEvent)
    @(negedge ref_clk);
    `CHK("localErrEvent", 1'b0, localErrEvent)
    // mid-run reset clears locks and results
    rd(CMD_REMOTE2_HIGH, cur[2][12:5]);
    `CHK("lowLocked", 5'h05, lowLocked)
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    `CHK("lowLocked", 5'h00, lowLocked)
    `CHK("localOver", 1'b0, localOver)
    `CHK("rdData", 8'h00, rdData)
    rd(CMD_REMOTE2_LOW, UNMAPPED_DATA);
    rd(CMD_LOCAL_HIGH, 8'h00);
    $display("test corner done");
    conclude();
  end
endmodule // testbench
`default_nettype wire
